// ### hw/lcd_timing_map.svh
`ifndef LCD_TIMING_MAP_SVH
`define LCD_TIMING_MAP_SVH
// register indices; the byte address on the bus is four times the index
`define IDX_PANEL_TYPE       18'h1ffe1
`define IDX_MODE_ONE         18'h1ffe2
`define IDX_POWER_SAVE       18'h1ffe3
`define IDX_HORIZ_SIZE       18'h1ffe4
`define IDX_VERT_SIZE_LOW    18'h1ffe5
`define IDX_VERT_SIZE_HIGH   18'h1ffe6
`define IDX_LINE_PULSE_START 18'h1ffe7
`define IDX_HORIZ_BLANK      18'h1ffe8
`define IDX_FRAME_PULSE_START 18'h1ffe9
`define IDX_VERT_BLANK       18'h1ffea
`define IDX_GPIO_CONFIG      18'h1fff8
`define IDX_GPIO_CONTROL     18'h1fff9
// field positions
`define BIT_ACTIVE_MATRIX    7
`define BIT_SW_INVERT        0
`define BIT_HW_INVERT_EN     1
`define BIT_HW_PS_EN         2
`define BIT_PWR_OVERRIDE     3
`define BIT_VND_STATUS       7
`define BIT_GPIO_ZERO        0
`define BIT_GPIO_FOUR        4
// codes and timing counts, in 8-pixel groups or lines
`define PS_CODE_SAVE         2'h0
`define PS_CODE_NORMAL       2'h3
`define HORIZ_BLANK_BIAS     8'h04
`define LINE_PULSE_BIAS      8'h02
`define REG_RESET            8'h00
`define AXI_OKAY             2'h0
`define AXI_DECERR           2'h3
`endif

// ### hw/lcd_timing_pkg.sv
package lcd_timing_pkg;
  typedef enum logic [1:0] {pwr_off, pwr_up, pwr_on, pwr_down} pwr_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  typedef struct packed {
    logic        aw_held;
    logic [17:0] aw_idx;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rbyte;
    logic [1:0]  rresp;
    logic        am;
    logic [1:0]  mode_one;
    logic [3:0]  ps_ctrl;
    logic [6:0]  hsize;
    logic [9:0]  vsize;
    logic [4:0]  lps;
    logic [4:0]  hblank;
    logic [5:0]  fps;
    logic [5:0]  vblank;
    logic        cfg0;
    logic        cfg4;
    logic        ctl0;
    logic        ctl4;
    logic [7:0]  hcnt;
    logic [10:0] vcnt;
    pwr_state_t  pwr;
    logic [11:0] pix;
    logic        line_p;
    logic        frame_p;
  } core_state_t;
endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; the level moves only when stages two and three agree
module pin_sync
  import lcd_timing_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st       = st;
    next_st.s1    = pin;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.level = (st.s2 == st.s3) ? st.s3 : st.level;
    if (!aresetn) begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign level = st.level;
endmodule

// ### hw/lcd_panel_timing.sv
`timescale 1ns/1ps
`include "lcd_timing_map.svh"
// Summary of operation
// - software invert bit selects inverse video
// - inversion applied after look-up table output
// - hardware enable picks pin (passive only) or software bit
// - passive: data bit eleven is invert or io4
// - override: power off, signals low immediately
// - hardware power save: io0 is request input
// - io0 input or output per config bit
// - power save field: 00 save, 11 normal
// - line width in 8-pixel groups, minus one
// - ten-bit line count minus one
// - active matrix line pulse (field+2) groups late
// - horizontal blank is (field+4) groups
// - active matrix frame pulse field lines late
// - vertical blank is field lines exactly
// - status bit high during vertical blank
module lcd_panel_timing
  import lcd_timing_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [19:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [19:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [11:0] lut_pixel_data,
  output logic             pixel_fetch,
  output logic [10:0]      panel_pixel_data,
  input  wire logic        panel_data_bit_eleven_in,
  output logic             panel_data_bit_eleven_out,
  output logic             panel_data_bit_eleven_oe,
  input  wire logic        general_io_pin_zero_in,
  output logic             general_io_pin_zero_out,
  output logic             general_io_pin_zero_oe,
  output logic             line_pulse,
  output logic             frame_pulse,
  output logic             panel_power_output,
  output logic             power_save_active
);
  core_state_t st;
  core_state_t next_st;
  logic        io0_level;
  logic        bit11_level;
  logic [7:0]  hlast;
  logic [10:0] vlast;
  logic [7:0]  line_pos;
  logic [10:0] frame_pos;
  logic        display;
  logic        vstat;
  logic        ps_req;
  logic        sig_en;
  logic        invert;
  logic        frame_end;
  logic        hw_ps_en;
  logic        hw_inv_en;

  // register index hit; shared by read and write decode
  function automatic logic reg_hit(input logic [17:0] idx);
    reg_hit = (idx >= `IDX_PANEL_TYPE && idx <= `IDX_VERT_BLANK) ||
              idx == `IDX_GPIO_CONFIG || idx == `IDX_GPIO_CONTROL;
  endfunction

  // read mux; unused bit positions return zero
  function automatic logic [7:0] reg_read(input logic [17:0] idx, input core_state_t s,
                                          input logic io0, input logic vs);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      `IDX_PANEL_TYPE:        d[`BIT_ACTIVE_MATRIX] = s.am;
      `IDX_MODE_ONE:          d[1:0] = s.mode_one;
      `IDX_POWER_SAVE:        d[3:0] = s.ps_ctrl;
      `IDX_HORIZ_SIZE:        d[6:0] = s.hsize;
      `IDX_VERT_SIZE_LOW:     d = s.vsize[7:0];
      `IDX_VERT_SIZE_HIGH:    d[1:0] = s.vsize[9:8];
      `IDX_LINE_PULSE_START:  d[4:0] = s.lps;
      `IDX_HORIZ_BLANK:       d[4:0] = s.hblank;
      `IDX_FRAME_PULSE_START: d[5:0] = s.fps;
      `IDX_VERT_BLANK:        d = {vs, 1'b0, s.vblank};
      `IDX_GPIO_CONFIG: begin
        d[`BIT_GPIO_ZERO] = s.cfg0;
        d[`BIT_GPIO_FOUR] = s.cfg4;
      end
      `IDX_GPIO_CONTROL: begin
        d[`BIT_GPIO_ZERO] = s.cfg0 ? s.ctl0 : io0;
        d[`BIT_GPIO_FOUR] = s.ctl4;
      end
      default:                d = 8'h00;
    endcase
    return d;
  endfunction

  pin_sync u_io0_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (general_io_pin_zero_in),
    .level   (io0_level)
  );

  pin_sync u_bit11_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (panel_data_bit_eleven_in),
    .level   (bit11_level)
  );

  // raster geometry; one clock is one 8-pixel group
  assign hlast     = {1'b0, st.hsize} + {3'b000, st.hblank} + `HORIZ_BLANK_BIAS;
  assign vlast     = {1'b0, st.vsize} + {5'b00000, st.vblank};
  assign line_pos  = {1'b0, st.hsize} + 8'h01 + {3'b000, st.lps} + `LINE_PULSE_BIAS;
  assign frame_pos = {1'b0, st.vsize} + {5'b00000, st.fps};
  assign display   = (st.hcnt <= {1'b0, st.hsize}) && (st.vcnt <= {1'b0, st.vsize});
  assign vstat     = st.vcnt > {1'b0, st.vsize};
  assign frame_end = (st.hcnt == hlast) && (st.vcnt == vlast);
  assign hw_ps_en  = st.ps_ctrl[`BIT_HW_PS_EN];
  assign hw_inv_en = st.mode_one[`BIT_HW_INVERT_EN];
  // reserved codes act as normal operation
  assign ps_req    = (st.ps_ctrl[1:0] == `PS_CODE_SAVE) || (hw_ps_en && io0_level);
  assign sig_en    = st.pwr != pwr_off;
  // pin only counts in passive mode, where it is an input
  assign invert    = hw_inv_en ? (!st.am && bit11_level) : st.mode_one[`BIT_SW_INVERT];

  always_comb begin
    next_st = st;
    // write channel: address and data taken in either order
    if (awvalid && awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = awaddr[19:2];
    end
    if (wvalid && wready) begin
      next_st.w_held = 1'b1;
      next_st.w_byte = wdata[7:0];
      next_st.w_lane = wstrb[0];
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = reg_hit(st.aw_idx) ? `AXI_OKAY : `AXI_DECERR;
      if (st.w_lane) begin
        case (st.aw_idx)
          `IDX_PANEL_TYPE:        next_st.am = st.w_byte[`BIT_ACTIVE_MATRIX];
          `IDX_MODE_ONE:          next_st.mode_one = st.w_byte[1:0];
          `IDX_POWER_SAVE:        next_st.ps_ctrl = st.w_byte[3:0];
          `IDX_HORIZ_SIZE:        next_st.hsize = st.w_byte[6:0];
          `IDX_VERT_SIZE_LOW:     next_st.vsize[7:0] = st.w_byte;
          `IDX_VERT_SIZE_HIGH:    next_st.vsize[9:8] = st.w_byte[1:0];
          `IDX_LINE_PULSE_START:  next_st.lps = st.w_byte[4:0];
          `IDX_HORIZ_BLANK:       next_st.hblank = st.w_byte[4:0];
          `IDX_FRAME_PULSE_START: next_st.fps = st.w_byte[5:0];
          `IDX_VERT_BLANK:        next_st.vblank = st.w_byte[5:0];
          `IDX_GPIO_CONFIG: begin
            next_st.cfg0 = st.w_byte[`BIT_GPIO_ZERO];
            next_st.cfg4 = st.w_byte[`BIT_GPIO_FOUR];
          end
          `IDX_GPIO_CONTROL: begin
            next_st.ctl0 = st.w_byte[`BIT_GPIO_ZERO];
            next_st.ctl4 = st.w_byte[`BIT_GPIO_FOUR];
          end
          default: ;
        endcase
      end
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // read channel: data sampled at the address edge
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rbyte  = reg_read(araddr[19:2], st, io0_level, vstat);
      next_st.rresp  = reg_hit(araddr[19:2]) ? `AXI_OKAY : `AXI_DECERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end

    // panel power sequencing
    case (st.pwr)
      pwr_on: begin
        if (ps_req) begin
          next_st.pwr = st.ps_ctrl[`BIT_PWR_OVERRIDE] ? pwr_off : pwr_down;
        end
      end
      pwr_down: begin
        // power already off; signals run out the frame so the panel sees a clean end
        if (st.ps_ctrl[`BIT_PWR_OVERRIDE] || frame_end) begin
          next_st.pwr = pwr_off;
        end else if (!ps_req) begin
          next_st.pwr = pwr_on;
        end
      end
      pwr_off: begin
        if (!ps_req) begin
          next_st.pwr = pwr_up;
        end
      end
      pwr_up: begin
        // signals run one frame before power returns
        if (ps_req) begin
          next_st.pwr = pwr_off;
        end else if (frame_end) begin
          next_st.pwr = pwr_on;
        end
      end
      default: next_st.pwr = pwr_off;
    endcase

    // raster counters, parked while signals are off
    if (!sig_en) begin
      next_st.hcnt = 8'h00;
      next_st.vcnt = 11'h000;
    end else if (st.hcnt >= hlast) begin
      next_st.hcnt = 8'h00;
      next_st.vcnt = (st.vcnt >= vlast) ? 11'h000 : st.vcnt + 11'h001;
    end else begin
      next_st.hcnt = st.hcnt + 8'h01;
    end

    // pixel, line and frame outputs, all low while signals are off
    next_st.pix = (sig_en && display) ? (lut_pixel_data ^ {12{invert}}) : 12'h000;
    next_st.line_p = sig_en && (st.hcnt == (st.am ? line_pos : {1'b0, st.hsize} + 8'h01));
    next_st.frame_p = sig_en && (st.am ? (st.vcnt == frame_pos) : (st.vcnt == 11'h000));

    if (!aresetn) begin
      next_st     = '0;
      next_st.pwr = pwr_off;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // bus handshakes; one write and one read in flight
  assign awready = !st.aw_held && !st.bvalid;
  assign wready  = !st.w_held && !st.bvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid  = st.rvalid;
  assign rresp   = st.rresp;
  assign rdata   = {24'h000000, st.rbyte};

  // panel side
  assign pixel_fetch        = sig_en && display;
  assign panel_pixel_data   = st.pix[10:0];
  assign line_pulse         = st.line_p;
  assign frame_pulse        = st.frame_p;
  assign panel_power_output = st.pwr == pwr_on;
  assign power_save_active  = st.pwr == pwr_off;

  // io0 never drives while it serves as the power save request
  assign general_io_pin_zero_oe  = st.cfg0 && !hw_ps_en;
  assign general_io_pin_zero_out = st.ctl0;

  // bit eleven: pixel out in active matrix, else invert input or io4
  always_comb begin
    if (st.am) begin
      panel_data_bit_eleven_oe  = 1'b1;
      panel_data_bit_eleven_out = st.pix[11];
    end else if (hw_inv_en) begin
      panel_data_bit_eleven_oe  = 1'b0;
      panel_data_bit_eleven_out = 1'b0;
    end else begin
      panel_data_bit_eleven_oe  = st.cfg4;
      panel_data_bit_eleven_out = st.ctl4;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sw_invert_data: assert property (pixel_fetch && !hw_inv_en |=>
    panel_pixel_data == ($past(lut_pixel_data[10:0]) ^ {11{$past(st.mode_one[0])}}))
    else $error("software invert not applied to pixel data");
  a_hw_invert_pin: assert property (pixel_fetch && hw_inv_en && !st.am |=>
    panel_pixel_data == ($past(lut_pixel_data[10:0]) ^ {11{$past(bit11_level)}}))
    else $error("hardware invert does not follow the pin");
  a_bit11_input: assert property (!st.am && hw_inv_en |-> !panel_data_bit_eleven_oe)
    else $error("bit eleven driven while used as invert input");
  a_override_off: assert property (st.pwr == pwr_on && ps_req && st.ps_ctrl[3] |=>
    power_save_active && !panel_power_output ##1 panel_pixel_data == 11'h000)
    else $error("override did not drop power and signals at once");
  a_io0_request: assert property (hw_ps_en |-> !general_io_pin_zero_oe)
    else $error("io0 driven while it is the power save request");
  a_io0_output: assert property (!hw_ps_en && st.cfg0 |->
    general_io_pin_zero_oe && general_io_pin_zero_out == st.ctl0)
    else $error("io0 output does not follow control bit");
  a_save_code: assert property (st.ps_ctrl[1:0] == 2'h0 && st.pwr == pwr_on |=>
    !panel_power_output)
    else $error("power save code did not remove panel power");
  a_line_wrap: assert property (sig_en && st.hcnt == hlast |=> st.hcnt == 8'h00)
    else $error("line did not end after the blank period");
  a_blank_status: assert property (sig_en && st.vcnt == {1'b0, st.vsize} && st.hcnt == hlast &&
    st.vblank != 6'h00 |=> vstat)
    else $error("blank status not set after last display line");
  a_write_answer: assert property (st.aw_held && st.w_held |=> bvalid)
    else $error("write not answered one cycle after both parts");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before being taken");

  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_save_entry: cover property (st.pwr == pwr_down ##1 st.pwr == pwr_off);
  c_frame_pulse: cover property (st.am && frame_pulse);
endmodule

// ### tb/panel_model.sv
`timescale 1ns/1ps
// panel side: measures line and frame spacing
module panel_model (
  input  wire logic aclk,
  input  wire logic line_pulse,
  input  wire logic frame_pulse,
  input  wire logic pixel_fetch,
  output int        line_cycles,
  output int        frame_cycles,
  output int        fetch_to_line
);
  int   lc = 0;
  int   fc = 0;
  int   sf = 0;
  logic fp_d = 1'b0;

  // sampled on the falling edge, clear of the design's launch edge
  always @(negedge aclk) begin
    lc++;
    fc++;
    sf++;
    if (pixel_fetch)
      sf = 0;
    if (line_pulse) begin
      line_cycles = lc;
      fetch_to_line = sf;
      lc = 0;
    end
    if (frame_pulse && !fp_d) begin
      frame_cycles = fc;
      fc = 0;
    end
    fp_d = frame_pulse;
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "lcd_timing_map.svh"
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [19:0] awaddr = 20'h0, araddr = 20'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, pixel_fetch, line_pulse, frame_pulse;
  logic [1:0]  bresp, rresp, rs, ws;
  logic [11:0] lut = 12'h5a3;
  logic [10:0] ppd;
  logic        b11_out, b11_oe, b11_drv = 1'b0, io0_out, io0_oe, io0_drv = 1'b0;
  logic        power, ps_active, saw0, saw1;
  wire         b11_in = b11_oe ? b11_out : b11_drv;
  wire         io0_in = io0_oe ? io0_out : io0_drv;
  int          mismatches = 0, checks = 0, line_cycles, frame_cycles, fetch_to_line, p_delay;
  logic [7:0]  msk [8] = '{8'h0f, 8'h7f, 8'hff, 8'h03, 8'h1f, 8'h1f, 8'h3f, 8'h3f};
  logic [7:0]  val [8] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02};
  logic [7:0]  mode [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
  logic        pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [10:0] pix [4] = '{11'h5a3, 11'h25c, 11'h25c, 11'h5a3};

  lcd_panel_timing i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lut_pixel_data(lut),
    .pixel_fetch(pixel_fetch), .panel_pixel_data(ppd), .panel_data_bit_eleven_in(b11_in),
    .panel_data_bit_eleven_out(b11_out), .panel_data_bit_eleven_oe(b11_oe),
    .general_io_pin_zero_in(io0_in), .general_io_pin_zero_out(io0_out),
    .general_io_pin_zero_oe(io0_oe), .line_pulse(line_pulse), .frame_pulse(frame_pulse),
    .panel_power_output(power), .power_save_active(ps_active));

  panel_model i_panel (.aclk(aclk), .line_pulse(line_pulse), .frame_pulse(frame_pulse),
    .pixel_fetch(pixel_fetch), .line_cycles(line_cycles), .frame_cycles(frame_cycles),
    .fetch_to_line(fetch_to_line));

  // 40 MHz
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a wait that runs out ends the run at once
  task automatic timed_out(input int n, input int max);
    if (n >= max) begin
      chk(32'h0, 32'h1);
      end_of_test;
    end
  endtask

  // one write; address and data offered together, each dropped once taken
  // ready and answer are taken at the falling edge, where they have settled for the next rising edge
  task automatic wr(input logic [17:0] idx, input logic [7:0] d);
    int   n;
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    n = 0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_ok = awready;
      w_ok = wready;
      b_ok = bvalid;
      ws = bresp;
      @(posedge aclk);
      n++;
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end while (b_ok !== 1'b1 && n < 50);
    bready <= 1'b0;
    timed_out(n, 50);
    #1;
  endtask

  task automatic rd_reg(input logic [17:0] idx);
    int   n;
    logic ar_ok;
    logic r_ok;
    n = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_ok = arready;
      r_ok = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      n++;
      if (ar_ok)
        arvalid <= 1'b0;
    end while (r_ok !== 1'b1 && n < 50);
    rready <= 1'b0;
    timed_out(n, 50);
    #1;
  endtask

  // sel 0 watches panel power, sel 1 the power save state
  task automatic wait_sig(input int sel, input logic want, input int max);
    int n;
    n = 0;
    while (((sel == 0) ? power : ps_active) !== want && n < max) begin
      @(posedge aclk);
      n++;
    end
    timed_out(n, max);
  endtask

  // pixel launched at the edge after a fetch cycle
  task automatic chk_pix(input logic [10:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pixel_fetch !== 1'b1 && n < 40);
    timed_out(n, 40);
    @(posedge aclk);
    #1;
    chk({21'h0, ppd}, {21'h0, exp});
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset value, unused bits, then the timing setup
    for (int i = 0; i < 8; i++) begin
      rd_reg(`IDX_POWER_SAVE + 18'(i));
      chk(rd & 32'h7f, 32'h0);
      wr(`IDX_POWER_SAVE + 18'(i), 8'hff);
      rd_reg(`IDX_POWER_SAVE + 18'(i));
      chk(rd & ((i == 7) ? 32'h7f : 32'hff), {24'h0, msk[i]});
      wr(`IDX_POWER_SAVE + 18'(i), val[i]);
    end
    rd_reg(18'h1fff0);
    chk({30'h0, rs}, 32'h3);
    chk(rd, 32'h0);
    wr(18'h1fff0, 8'hff);
    chk({30'h0, ws}, 32'h3);
    wait_sig(0, 1'b1, 400);
    repeat (130) @(posedge aclk);
    chk(line_cycles, 32'd10);
    chk(frame_cycles, 32'd60);
    p_delay = fetch_to_line;
    // status seen both in and out of vertical blank
    saw0 = 1'b0;
    saw1 = 1'b0;
    repeat (25) begin
      rd_reg(`IDX_VERT_BLANK);
      if (rd[7])
        saw1 = 1'b1;
      else
        saw0 = 1'b1;
    end
    chk({30'h0, saw1, saw0}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_MODE_ONE, mode[i]);
      b11_drv <= pin[i];
      repeat (8) @(posedge aclk);
      chk_pix(pix[i]);
    end
    wr(`IDX_MODE_ONE, 8'h00);
    wr(`IDX_GPIO_CONFIG, 8'h01);
    wr(`IDX_GPIO_CONTROL, 8'h01);
    chk({30'h0, io0_oe, io0_out}, 32'h3);
    wr(`IDX_GPIO_CONFIG, 8'h00);
    io0_drv <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_reg(`IDX_GPIO_CONTROL);
    chk(rd, 32'h1);
    wr(`IDX_GPIO_CONFIG, 8'h01);
    wr(`IDX_POWER_SAVE, 8'h07);
    chk({31'h0, io0_oe}, 32'h0);
    wait_sig(1, 1'b1, 200);
    io0_drv <= 1'b0;
    wait_sig(0, 1'b1, 400);
    // override: request drops power without waiting for frame end
    wr(`IDX_POWER_SAVE, 8'h0f);
    io0_drv <= 1'b1;
    wait_sig(1, 1'b1, 10);
    chk({31'h0, power}, 32'h0);
    io0_drv <= 1'b0;
    wr(`IDX_POWER_SAVE, 8'h03);
    wait_sig(0, 1'b1, 400);
    wr(`IDX_POWER_SAVE, 8'h00);
    wait_sig(1, 1'b1, 200);
    wr(`IDX_POWER_SAVE, 8'h03);
    wait_sig(0, 1'b1, 400);
    wr(`IDX_PANEL_TYPE, 8'h80);
    chk({31'h0, b11_oe}, 32'h1);
    repeat (130) @(posedge aclk);
    chk(fetch_to_line - p_delay, 32'd3);
    end_of_test;
  end
endmodule
